// file: include/rsrc_regs.vh
`ifndef RSRC_REGS_VH
`define RSRC_REGS_VH
// register byte addresses (word aligned)
`define RSRC_ADDR_STATUS 4'h0
`define RSRC_ADDR_CTRL 4'h4
`define RSRC_ADDR_OPTION 4'h8
// status field positions
`define RSRC_ST_POR 7
`define RSRC_ST_STOP 6
`define RSRC_ST_WDT 5
`define RSRC_ST_EXT 4
// control field positions
`define RSRC_CT_PINRST 0
`define RSRC_CT_DBGRST 1
`define RSRC_CT_STOP 2
// option field positions
`define RSRC_OP_XTAL 0
`define RSRC_OP_WDTRES 1
`define RSRC_OP_BOAO 2
// reset values
`define RSRC_STATUS_RST 8'h80
`define RSRC_CTRL_RST 8'h00
`define RSRC_OPTION_RST 8'h02
// timing
`define RSRC_HOLD_SHORT 16'h0042
`define RSRC_HOLD_XTAL 16'h1388
`define RSRC_OSC_START_NS 4000
`define RSRC_CLK_PERIOD_NS 5
`define RSRC_OSC_START_CYC ((`RSRC_OSC_START_NS+`RSRC_CLK_PERIOD_NS-1)/`RSRC_CLK_PERIOD_NS)
`define RSRC_PIN_FILTER 3
`define RSRC_VECTOR_HI 16'h0002
`define RSRC_VECTOR_LO 16'h0003
`endif

// file: hdl/rsrc_reset_ctrl.v
// Contract
// - hold reset 66 oscillator cycles after oscillator start
// - crystal option lengthens hold to 5000 oscillator cycles
// - wait 4 us oscillator start-up before hold count
// - supply resets count from supply good, not detection
// - stay in reset while pin still asserted after count
// - leave reset on first clock edge after pin release
// - ignore pin pulses under three clocks, four always resets
// - pin resets only when alternate reset function selected
// - reset makes all gpio inputs with pull-ups off
// - cpu and peripherals idle, oscillators keep running
// - control registers load reset values on reset; ctrl and option here reload only on rst_i
// - cpu fetches vector from 0002H and 0003H on exit
// - system reset selects internal oscillator as clock
// - stop recovery by watchdog timeout or enabled gpio change
// - watchdog resets when option is 1, else interrupts
// - watchdog-caused reset sets watchdog cause flag
// - pin-caused reset sets pin cause flag
// - power-on or brownout reset sets power-on flag
// - brownout holds reset, then runs full sequence
// - option keeps brownout monitor active in stop mode
// - debugger reset resets chip but not the debugger
// - stop recovery resets cpu, keeps registers but two
// - debug pin low in stop gives full reset, power-on flag
// - any stop recovery sets stop-recovery flag
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "rsrc_regs.vh"
module rsrc_reset_ctrl #(
    parameter GPIO_N = 8,
    parameter [15:0] HOLD_XTAL = `RSRC_HOLD_XTAL,
    parameter [15:0] OSC_START = `RSRC_OSC_START_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wb_err_o,
    // reset sources, all asynchronous
    input wire supply_good_i,
    input wire supply_brownout_i,
    input wire reset_pin_n_i,
    input wire debug_pin_n_i,
    input wire watchdog_timeout_i,
    input wire [GPIO_N-1:0] gpio_i,
    input wire [GPIO_N-1:0] gpio_wake_en_i,
    // oscillator clock-enable pulse
    input wire internal_precision_osc_tick_i,
    // mode and debugger
    input wire stop_mode_i,
    input wire debugger_reset_req_i,
    // system outputs
    output reg system_reset_o,
    output reg cpu_reset_o,
    output reg gpio_force_input_o,
    output reg clock_select_ipo_o,
    output reg osc_enable_o,
    output reg watchdog_control_reg_reset_o,
    output reg vector_fetch_o,
    output reg [15:0] vector_addr_o,
    output reg watchdog_irq_o,
    output reg debugger_clear_o,
    output reg brownout_monitor_en_o
);
// ============================================================
// states of the reset sequencer; RUN is the only one out of reset
localparam ST_RUN = 3'h0; // cpu running, waiting for a cause
localparam ST_SUPPLY = 3'h1; // supply low, nothing counts yet
localparam ST_START = 3'h2; // oscillator start-up wait
localparam ST_HOLD = 3'h3; // counting oscillator ticks
localparam ST_PIN = 3'h4; // count done, waiting for pin release
localparam ST_VEC1 = 3'h5; // fetch high vector byte
localparam ST_VEC2 = 3'h6; // fetch low vector byte
// cause codes written into the status byte
localparam [7:0] CAUSE_POR = 8'h80; // power-on, brownout or debugger
localparam [7:0] CAUSE_WDT = 8'h20; // watchdog timeout outside stop
localparam [7:0] CAUSE_PIN = 8'h10; // external reset pin
// sequencer state and shared start-up / hold counter
reg [2:0] state;
reg [15:0] cnt;
// set while the running sequence is a stop recovery, not a full reset
reg is_stop_rec;
// software visible bytes
reg [7:0] status;
reg [7:0] ctrl;
reg [7:0] option;
// ============================================================
// input synchronisers, generated per asynchronous bit
// every pin and the debugger request crosses into the clock domain
// through two flops; only the second flop is read, so a metastable
// first stage never reaches the decode
localparam NS = 6 + GPIO_N;
wire [NS-1:0] raw_in;
wire [NS-1:0] syn;
assign raw_in = {gpio_i, supply_good_i, supply_brownout_i, reset_pin_n_i,
                 debug_pin_n_i, watchdog_timeout_i, debugger_reset_req_i};
genvar gi;
generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
        reg s1;
        reg s2;
        always @(posedge clk_i) begin
            s1 <= raw_in[gi];
            s2 <= s1;
        end
        assign syn[gi] = s2;
    end
endgenerate
// synchronised copies, named by source
wire dbg_req_s = syn[0];
wire wdt_s = syn[1];
wire dbg_pin_n_s = syn[2];
wire pin_n_s = syn[3];
wire brown_s = syn[4];
wire sup_good_s = syn[5];
wire [GPIO_N-1:0] gpio_s = syn[NS-1:6];
// ============================================================
// pin glitch filter: low for four sampled clocks counts as assertion
// the counter saturates at three, so the pin must read low on four
// synchronised clocks before it counts; shorter glitches are dropped
// the filter is held clear while the alternate pin function is off
reg [1:0] pin_lo_cnt;
wire pin_en = ctrl[`RSRC_CT_PINRST];
wire pin_asserted = pin_en & ~pin_n_s & (pin_lo_cnt == 2'h3);
always @(posedge clk_i) begin
    if (rst_i || pin_n_s || !pin_en) begin
        pin_lo_cnt <= 2'h0;
    end else if (pin_lo_cnt != 2'h3) begin
        pin_lo_cnt <= pin_lo_cnt + 2'h1;
    end
end
// ============================================================
// edge detect on wake gpio and watchdog
// both delay stages follow the synchronised value through reset, so no
// false edge appears when reset is released
reg [GPIO_N-1:0] gpio_d;
reg wdt_d;
wire wdt_evt = wdt_s & ~wdt_d;
wire gpio_wake = |((gpio_s ^ gpio_d) & gpio_wake_en_i);
always @(posedge clk_i) begin
    gpio_d <= gpio_s;
    wdt_d <= wdt_s;
end
// ============================================================
// request decode, priority supply > pin > debug > watchdog
// a bus request is taken while ack is low; a status read is decoded
// here because the read clears the cause bits in the sequencer
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire rd_status = req & ~wb_we_i & (wb_adr_i == `RSRC_ADDR_STATUS);
// option bits change only by software writes
wire wdt_reset_opt = option[`RSRC_OP_WDTRES];
wire bo_active = brown_s & (~stop_mode_i | option[`RSRC_OP_BOAO]);
wire supply_bad = bo_active | ~sup_good_s;
wire dbg_rst = dbg_req_s | ctrl[`RSRC_CT_DBGRST] |
               (stop_mode_i & ~dbg_pin_n_s);
wire wdt_rst = wdt_evt & wdt_reset_opt & ~stop_mode_i;
wire stop_rec = stop_mode_i & (wdt_evt | gpio_wake);
// every state but RUN keeps something in reset
wire busy = (state != ST_RUN);
// hold length follows the crystal option as it stands while counting
wire [15:0] hold_len = option[`RSRC_OP_XTAL] ? HOLD_XTAL :
                       `RSRC_HOLD_SHORT;
// a cause taken this cycle beats a status read in the same cycle
wire new_cause = supply_bad | ((state == ST_RUN) &
                 (pin_asserted | dbg_rst | wdt_rst | stop_rec));
// ============================================================
// sequencer
// a supply dip overrides every state and restarts the whole count, so
// the hold always runs from the moment the supply is good again
always @(posedge clk_i) begin
    if (rst_i) begin
        state <= ST_SUPPLY;
        cnt <= 16'h0000;
        is_stop_rec <= 1'b0;
        status <= `RSRC_STATUS_RST;
        watchdog_irq_o <= 1'b0;
    end else begin
        // a timeout with the reset option off interrupts, and in stop also starts a stop recovery
        watchdog_irq_o <= wdt_evt & ~wdt_reset_opt;
        if (supply_bad) begin
            // restart from supply good each time it dips
            state <= ST_SUPPLY;
            is_stop_rec <= 1'b0;
            status <= CAUSE_POR;
        end else begin
            case (state)
            ST_RUN: begin
                // first cause by priority wins; others this cycle are lost
                if (pin_asserted) begin
                    state <= ST_START;
                    status <= CAUSE_PIN;
                    is_stop_rec <= 1'b0;
                end else if (dbg_rst) begin
                    state <= ST_START;
                    status <= CAUSE_POR;
                    is_stop_rec <= 1'b0;
                end else if (wdt_rst) begin
                    state <= ST_START;
                    status <= CAUSE_WDT;
                    is_stop_rec <= 1'b0;
                end else if (stop_rec) begin
                    state <= ST_START;
                    status <= {2'h1, wdt_evt, 5'h00};
                    is_stop_rec <= 1'b1;
                end
                cnt <= 16'h0000;
            end
            ST_SUPPLY: begin
                // supply is good again: start the oscillator wait
                state <= ST_START;
                cnt <= 16'h0000;
            end
            ST_START: begin
                // oscillator is not trusted yet, so count system clocks
                if (cnt >= OSC_START - 16'h0001) begin
                    state <= ST_HOLD;
                    cnt <= 16'h0000;
                end else begin
                    cnt <= cnt + 16'h0001;
                end
            end
            ST_HOLD: begin
                // one step per oscillator tick, not per system clock
                if (cnt >= hold_len) begin
                    state <= ST_PIN;
                end else if (internal_precision_osc_tick_i) begin
                    cnt <= cnt + 16'h0001;
                end
            end
            ST_PIN: begin
                // a pin held past the count keeps the chip in reset
                if (pin_n_s || !pin_en) begin
                    state <= ST_VEC1;
                end
            end
            ST_VEC1: begin
                // cpu fetches the high vector byte
                state <= ST_VEC2;
            end
            ST_VEC2: begin
                // cpu fetches the low vector byte, then runs
                state <= ST_RUN;
            end
            default: begin
                // unused codes fall back to running
                state <= ST_RUN;
            end
            endcase
        end
        // reading clears the cause bits unless a cause lands now
        if (rd_status && !new_cause) begin
            status <= 8'h00;
        end
    end
end
// ============================================================
// outputs, registered
// registered so that no decode glitch reaches the reset nets
always @(posedge clk_i) begin
    if (rst_i) begin
        system_reset_o <= 1'b1;
        cpu_reset_o <= 1'b1;
        gpio_force_input_o <= 1'b1;
        clock_select_ipo_o <= 1'b1;
        osc_enable_o <= 1'b1;
        watchdog_control_reg_reset_o <= 1'b1;
        vector_fetch_o <= 1'b0;
        vector_addr_o <= `RSRC_VECTOR_HI;
        debugger_clear_o <= 1'b0;
        brownout_monitor_en_o <= 1'b1;
    end else begin
        // registers reset only for full resets; stop recovery spares them
        system_reset_o <= busy & ~is_stop_rec;
        // cpu is released during the two vector fetch cycles
        cpu_reset_o <= busy & (state != ST_VEC1) & (state != ST_VEC2);
        // pins float as inputs so nothing outside is driven in reset
        gpio_force_input_o <= busy & ~is_stop_rec;
        // any reset or recovery falls back to the internal oscillator
        clock_select_ipo_o <= busy;
        // the oscillators never stop for reset
        osc_enable_o <= 1'b1;
        // watchdog control is reset by recoveries as well
        watchdog_control_reg_reset_o <= busy;
        // high byte address first, then low byte
        vector_fetch_o <= (state == ST_VEC1) | (state == ST_VEC2);
        vector_addr_o <= (state == ST_VEC2) ? `RSRC_VECTOR_LO :
                         `RSRC_VECTOR_HI;
        // the debug block stays out of this reset; this only clears its
        // request latch during a full reset
        debugger_clear_o <= busy & ~is_stop_rec;
        // brownout monitor sleeps in stop unless the option keeps it on
        brownout_monitor_en_o <= ~stop_mode_i | option[`RSRC_OP_BOAO];
    end
end
// ============================================================
// wishbone slave: ack one cycle after the request, for one cycle;
// req and rd_status are decoded above so the sequencer can see them
// unmapped addresses answer with zero and ignore writes
wire hit = (wb_adr_i == `RSRC_ADDR_STATUS) | (wb_adr_i == `RSRC_ADDR_CTRL) |
           (wb_adr_i == `RSRC_ADDR_OPTION);
assign wb_err_o = 1'b0;
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        ctrl <= `RSRC_CTRL_RST;
        option <= `RSRC_OPTION_RST;
    end else begin
        wb_ack_o <= req;
        // the debugger bit clears itself once a full reset has begun;
        // a write in the same cycle comes later and wins
        if (state == ST_START && !is_stop_rec) begin
            ctrl[`RSRC_CT_DBGRST] <= 1'b0;
        end
        // writes use byte lane 0 only; the registers are one byte wide
        if (req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `RSRC_ADDR_CTRL) begin
                ctrl <= wb_dat_i[7:0];
            end else if (wb_adr_i == `RSRC_ADDR_OPTION) begin
                option <= wb_dat_i[7:0];
            end
        end
        // read data is registered and stands until the next read or an unmapped address
        if (req && !wb_we_i) begin
            case (wb_adr_i)
            `RSRC_ADDR_STATUS: wb_dat_o <= {24'h000000, status};
            `RSRC_ADDR_CTRL: wb_dat_o <= {24'h000000, ctrl};
            `RSRC_ADDR_OPTION: wb_dat_o <= {24'h000000, option};
            default: wb_dat_o <= 32'h00000000;
            endcase
        end
        // an unmapped address never shows stale data
        if (!hit) begin
            wb_dat_o <= 32'h00000000;
        end
    end
end
endmodule

// file: test/rsrc_far_model.sv
`timescale 1ns/10ps
module rsrc_far_model (
    // system clock and bench request
    input wire clk_i,
    input wire pin_low_i,
    // pin and oscillator toward the block
    output wire reset_pin_n_o,
    output reg osc_tick_o
);
    reg half;
    // pin has a pull-up, so a released pin reads high
    assign reset_pin_n_o = !pin_low_i;
    // oscillator runs free at half rate, reset or not
    initial begin
        half = 1'b0;
        osc_tick_o = 1'b0;
    end
    always @(posedge clk_i) begin
        half <= !half;
        osc_tick_o <= half;
    end
endmodule

// file: test/rsrc_reset_ctrl_chk.sv
`timescale 1ns/10ps
module rsrc_reset_ctrl_chk (
    // watched ports
    input wire clk_i,
    input wire rst_i,
    input wire reset_pin_n_i,
    input wire supply_brownout_i,
    input wire internal_precision_osc_tick_i,
    input wire system_reset_o,
    input wire gpio_force_input_o,
    input wire clock_select_ipo_o,
    input wire osc_enable_o,
    input wire vector_fetch_o,
    input wire [15:0] vector_addr_o,
    input wire watchdog_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int tcnt;
    // ticks seen in this hold; start-up ticks make it an upper bound only
    always @(posedge clk_i) begin
        if (rst_i || !system_reset_o)
            tcnt <= 0;
        else if (internal_precision_osc_tick_i)
            tcnt <= tcnt + 1;
    end
    sequence s_vec;
        vector_addr_o == 16'h0002 ##1 vector_addr_o == 16'h0003;
    endsequence
    chk_hold_count: assert property (
        $fell(system_reset_o) |-> tcnt >= 66) else $error("hold too short");
    chk_pin_release: assert property (
        $fell(system_reset_o) |-> $past(reset_pin_n_i, 2))
        else $error("left reset with pin low");
    chk_gpio_input: assert property (
        system_reset_o |-> gpio_force_input_o) else $error("gpio not input");
    chk_osc_running: assert property (
        osc_enable_o) else $error("oscillator stopped");
    chk_vector_order: assert property (
        $rose(vector_fetch_o) |-> s_vec) else $error("vector order");
    chk_clock_ipo: assert property (
        system_reset_o |-> clock_select_ipo_o) else $error("clock not ipo");
    chk_irq_pulse: assert property (
        watchdog_irq_o |=> !watchdog_irq_o) else $error("irq not a pulse");
    chk_brownout_hold: assert property (
        supply_brownout_i [*5] |-> system_reset_o)
        else $error("brownout not held");
endmodule
bind rsrc_reset_ctrl rsrc_reset_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .reset_pin_n_i(reset_pin_n_i), .supply_brownout_i(supply_brownout_i),
    .internal_precision_osc_tick_i(internal_precision_osc_tick_i),
    .system_reset_o(system_reset_o), .gpio_force_input_o(gpio_force_input_o),
    .clock_select_ipo_o(clock_select_ipo_o), .osc_enable_o(osc_enable_o),
    .vector_fetch_o(vector_fetch_o), .vector_addr_o(vector_addr_o),
    .watchdog_irq_o(watchdog_irq_o));

// file: test/tb_rsrc_reset_ctrl.sv
`timescale 1ns/10ps
module tb_rsrc_reset_ctrl;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, bo = 1'b0, pin_low = 1'b0;
    reg wdog = 1'b0, stop = 1'b0, dreq = 1'b0, dpin_n = 1'b1;
    reg [3:0] adr = 4'h0;
    reg [7:0] wd = 8'h00, gpio = 8'h00, wake = 8'h00;
    reg [31:0] q;
    wire [31:0] rd;
    wire ack, pin_n, tick, sres, cres, irq;
    int mismatches = 0;
    int n_checks = 0;
    // ================================================
    // clock, block and far side
    always #2.5 clk_i = !clk_i;
    rsrc_reset_ctrl #(.HOLD_XTAL(16'h0014), .OSC_START(16'h0004)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h0, wd}),
        .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(), .supply_good_i(1'b1),
        .supply_brownout_i(bo), .reset_pin_n_i(pin_n), .debug_pin_n_i(dpin_n),
        .watchdog_timeout_i(wdog), .gpio_i(gpio), .gpio_wake_en_i(wake),
        .internal_precision_osc_tick_i(tick), .stop_mode_i(stop),
        .debugger_reset_req_i(dreq), .system_reset_o(sres), .cpu_reset_o(cres),
        .gpio_force_input_o(), .clock_select_ipo_o(), .osc_enable_o(),
        .watchdog_control_reg_reset_o(), .vector_fetch_o(), .vector_addr_o(),
        .watchdog_irq_o(irq), .debugger_clear_o(), .brownout_monitor_en_o());
    rsrc_far_model u_far (.clk_i(clk_i), .pin_low_i(pin_low),
        .reset_pin_n_o(pin_n), .osc_tick_o(tick));
    // ================================================
    // shared tasks
    task chk(input [31:0] g, input [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // one classic cycle; held until ack is sampled high
    task wb(input w, input [3:0] a, input [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        // only the watchdog process ends a wait that never answers
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // bounded wait on the cpu reset level
    task wait_cpu(input v);
        int n;
        n = 0;
        while (cres !== v && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, cres === v}, 32'h1);
    endtask
    task cause(input [7:0] e);
        wb(1'b0, 4'h0, 8'h00);
        chk(q, {24'h0, e});
    endtask
    // ================================================
    // scenarios
    task t_por;
        wait_cpu(1'b0);
        cause(8'h80);
        cause(8'h00);
        wb(1'b0, 4'h8, 8'h00);
        chk(q, 32'h2);
        wb(1'b0, 4'hC, 8'h00);
        chk(q, 32'h0);
        $display("test power-on done");
    endtask
    task t_pin;
        wb(1'b0, 4'h4, 8'h00);
        chk(q, 32'h0);
        @(posedge clk_i) pin_low <= 1'b1;
        repeat (10) @(posedge clk_i);
        pin_low <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(sres, 32'h0);
        wb(1'b1, 4'h4, 8'h01);
        @(posedge clk_i) pin_low <= 1'b1;
        repeat (2) @(posedge clk_i);
        pin_low <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(sres, 32'h0);
        pin_low <= 1'b1;
        repeat (4) @(posedge clk_i);
        pin_low <= 1'b0;
        wait_cpu(1'b1);
        wait_cpu(1'b0);
        cause(8'h10);
        @(posedge clk_i) pin_low <= 1'b1;
        repeat (400) @(posedge clk_i);
        chk(cres, 32'h1);
        pin_low <= 1'b0;
        wait_cpu(1'b0);
        cause(8'h10);
        $display("test pin done");
    endtask
    task t_wdog;
        @(posedge clk_i) wdog <= 1'b1;
        wait_cpu(1'b1);
        wdog <= 1'b0;
        wait_cpu(1'b0);
        cause(8'h20);
        wb(1'b1, 4'h8, 8'h00);
        @(posedge clk_i) wdog <= 1'b1;
        q = 0;
        repeat (10) @(posedge clk_i) if (irq === 1'b1) q++;
        chk(q, 32'h1);
        chk(cres, 32'h0);
        wdog <= 1'b0;
        wb(1'b1, 4'h8, 8'h02);
        $display("test watchdog done");
    endtask
    task t_stop;
        @(posedge clk_i) stop <= 1'b1;
        wake <= 8'h01;
        @(posedge clk_i) gpio <= 8'h01;
        wait_cpu(1'b1);
        stop <= 1'b0;
        wait_cpu(1'b0);
        cause(8'h40);
        $display("test stop recovery done");
    endtask
    task t_other;
        wb(1'b1, 4'h4, 8'h02);
        wait_cpu(1'b1);
        wait_cpu(1'b0);
        cause(8'h80);
        @(posedge clk_i) dreq <= 1'b1;
        wait_cpu(1'b1);
        dreq <= 1'b0;
        wait_cpu(1'b0);
        cause(8'h80);
        @(posedge clk_i) stop <= 1'b1;
        dpin_n <= 1'b0;
        wait_cpu(1'b1);
        stop <= 1'b0;
        dpin_n <= 1'b1;
        wait_cpu(1'b0);
        cause(8'h80);
        @(posedge clk_i) bo <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk(sres, 32'h1);
        bo <= 1'b0;
        wait_cpu(1'b0);
        cause(8'h80);
        $display("test debugger and brownout done");
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // the whole run needs well under ten thousand cycles
    initial begin
        #200000;
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_por;
        t_pin;
        t_wdog;
        t_stop;
        t_other;
        end_sim;
    end
endmodule
